// ---- nmea_sentence_command_port_tb.sv ----
/*
 * self-checking bench of the sentence/command port: engine stub, host
 * model, command frames, baud change and supply drop.
 * assumes nsc_port with its default prefix and a 20 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "nsc_map.svh"
// ======================================================
// bench top
module nmea_sentence_command_port_tb;
  localparam int DIV0 = `NSC_TB_CLK_HZ / `NSC_BAUD_DEFAULT; // 96 cycles
  localparam int DIV5 = `NSC_TB_CLK_HZ / `NSC_BAUD_LIST_5; // 8 cycles
  logic sys_clk = 1'b0; // system clock
  logic rst_n = 1'b0; // sync reset, active low
  logic main_sup = 1'b1; // main supply present
  logic rx_line; // host to port
  logic tx_line; // port to host
  logic nav_req, nav_valid = 1'b0, nav_last = 1'b0, nav_ready;
  logic [2:0] nav_type, typ;
  logic [7:0] nav_data = 8'h00;
  logic act; // action pulse
  logic [9:0] act_num_o, act_num;
  logic [15:0] act_arg_o, act_arg;
  logic req_seen = 1'b0, taken = 1'b0;
  int act_count = 0;
  int num_errors = 0;
  int num_checks = 0;
  logic [2:0] type_q[$]; // requested sentence types
  // ======================================================
  // clock, design and host model
  initial forever #25 sys_clk = ~sys_clk;
  nsc_port #(.CLK_HZ(`NSC_TB_CLK_HZ)) dut (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .main_supply_i(main_sup),
    .backup_supply_i(1'b1), .rx_i(rx_line), .tx_o(tx_line),
    .nav_req_o(nav_req), .nav_type_o(nav_type), .nav_data_i(nav_data),
    .nav_valid_i(nav_valid), .nav_last_i(nav_last),
    .nav_ready_o(nav_ready), .action_o(act), .action_num_o(act_num_o),
    .action_arg_o(act_arg_o)
  );
  nsc_host_model #(.DIV(DIV0)) host (
    .sys_clk_i(sys_clk), .tx_line_i(tx_line), .rx_line_o(rx_line)
  );
  // ======================================================
  // engine stub: one-byte sentences, byte marks the type, bit0 high
  always @(posedge sys_clk) begin
    if (nav_valid && nav_ready === 1'b1) taken = 1'b1;
    if (nav_req === 1'b1) begin
      req_seen = 1'b1;
      typ = nav_type;
      type_q.push_back(nav_type);
    end
    // action pulses counted with what they carry
    if (act === 1'b1) begin
      act_count++;
      act_num = act_num_o;
      act_arg = act_arg_o;
    end
  end
  // engine drives off-edge, holds valid until taken
  always @(negedge sys_clk) begin
    if (taken) begin
      nav_valid = 1'b0;
      taken = 1'b0;
    end
    if (req_seen) begin
      nav_data = 8'h41 | {4'h0, typ, 1'b0};
      nav_valid = 1'b1;
      nav_last = 1'b1;
      req_seen = 1'b0;
    end
  end
  // ======================================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction
  // frame: dollar, body, star, two hex digits, CR LF
  task automatic send_cmd(input string body, input bit bad);
    logic [7:0] ck;
    ck = 8'h00;
    host.send_byte(`NSC_CH_DOLLAR);
    for (int i = 0; i < body.len(); i++) begin
      ck ^= body[i];
      host.send_byte(body[i]);
    end
    if (bad) ck = ~ck;
    host.send_byte(`NSC_CH_STAR);
    host.send_byte(hexc(ck[7:4]));
    host.send_byte(hexc(ck[3:0]));
    host.send_byte(`NSC_CH_CR);
    host.send_byte(`NSC_CH_LF);
  endtask
  // forget old bytes, then wait boundedly for a fresh one
  task automatic next_byte();
    host.seen_q.delete();
    host.width_q.delete();
    for (int k = 0; k < 40000 && host.seen_q.size() == 0; k++)
      @(posedge sys_clk);
    #1;
  endtask
  // ======================================================
  // scenarios
  task automatic t_power_on();
    for (int k = 0; k < 30000 && host.seen_q.size() == 0; k++)
      @(posedge sys_clk);
    check("first byte", host.seen_q[0], 32'h0000_0041);
    check("start rate", host.width_q[0], DIV0);
  endtask
  task automatic t_bad_sum();
    send_cmd("PXYZ150,7", 1'b1);
    repeat (100) @(posedge sys_clk);
    check("bad sum action", act_count, 32'h0000_0000);
  endtask
  task automatic t_action();
    send_cmd("PXYZ150,7", 1'b0);
    repeat (100) @(posedge sys_clk);
    check("action count", act_count, 32'h0000_0001);
    check("action number", act_num, 32'h0000_0096);
    check("action arg", act_arg, 32'h0000_0007);
  endtask
  task automatic t_baud();
    send_cmd("PXYZ251,115200", 1'b0);
    // byte in flight ends at the old rate first
    repeat (2000) @(posedge sys_clk);
    next_byte();
    check("new rate", host.width_q[0], DIV5);
    check("setting no action", act_count, 32'h0000_0001);
  endtask
  task automatic t_supply();
    @(negedge sys_clk);
    main_sup = 1'b0;
    // long enough for the decoder to finish a cut frame
    repeat (2000) @(negedge sys_clk);
    main_sup = 1'b1;
    next_byte();
    check("rate after main", host.width_q[0], DIV0);
    check("bytes resume", host.seen_q[0][0], 32'h0000_0001);
  endtask
  // mask down to one type: later requests only ask for that type
  task automatic t_mask();
    int n;
    send_cmd("PXYZ314,2", 1'b0);
    repeat (100) @(posedge sys_clk);
    n = type_q.size();
    for (int k = 0; k < 20000 && type_q.size() < n + 2; k++)
      @(posedge sys_clk);
    check("masked type", type_q[type_q.size() - 1], 1);
    check("mask no action", act_count, 32'h0000_0001);
  endtask
  task automatic t_types();
    for (int i = 0; i < `NSC_NTYPES; i++)
      check("type order", type_q[i], i);
  endtask
  // ======================================================
  // verdict, reached by the main sequence or the watchdog
  task automatic test_done();
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // main sequence; command frames at the default rate dominate run time,
  // about 70k cycles with the shortened bench clock rate
  initial begin
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    t_power_on();
    t_bad_sum();
    t_action();
    t_baud();
    t_supply();
    t_mask();
    t_types();
    test_done();
  end
  // watchdog past the expected run, still under the cycle budget
  initial begin
    repeat (32'h0001_5F90) @(posedge sys_clk);
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire

// ---- nsc_fifo.sv ----
/*
 * synchronous fifo, width and depth parameters, valid/ready both sides.
 * assumes one clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module nsc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // streams
  nsc_stream_if.snk in_s,
  nsc_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH]; // storage
  logic [AW-1:0] wr_ptr; // write index
  logic [AW-1:0] rd_ptr; // read index
  logic [AW:0] count; // words held
  logic push;
  logic pop;
  logic [AW:0] next_count;
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign out_s.valid = (count != '0);
  assign out_s.data = mem[rd_ptr];
  // ======================================================
  // storage write, no reset needed on data
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end
  // pointers and fill level; ready registered so the top sees a flop
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_s.ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      in_s.ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
  a_fifo_ready: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    in_s.ready |-> count != (AW+1)'(DEPTH))
    else $error("fifo ready while full");
endmodule
`default_nettype wire

// ---- nsc_host_model.sv ----
/*
 * host controller model on the serial link: sends command frames to the
 * port's receive pin and decodes the sentence bytes seen on its transmit pin.
 * assumes the port's 20 MHz clock, 8N1 framing, idle-high lines.
 */
`timescale 1ns/1ps
`default_nettype none
`include "nsc_map.svh"
// ======================================================
// host side of the serial link
module nsc_host_model #(
  parameter int DIV = `NSC_CLK_HZ / `NSC_BAUD_DEFAULT
) (
  // clock
  input wire logic sys_clk_i,
  // serial lines, named from the port's side
  input wire logic tx_line_i,
  output logic rx_line_o
);
  logic [7:0] seen_q[$]; // decoded sentence bytes
  int width_q[$]; // start bit length of each byte
  logic [7:0] b; // byte being decoded
  int w; // start bit length in cycles
  // line idles high between frames
  initial rx_line_o = 1'b1;
  // one 8N1 frame at the default rate, lsb first, launched off-edge
  task automatic send_byte(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge sys_clk_i);
      rx_line_o = f[i];
      repeat (DIV - 1) @(negedge sys_clk_i);
    end
  endtask
  // decoder learns the rate from each start bit, so data bit0 must be
  // high; a frame cut short leaves one garbage byte behind
  always begin
    @(posedge sys_clk_i iff tx_line_i === 1'b1);
    @(posedge sys_clk_i iff tx_line_i === 1'b0);
    w = 0;
    while (tx_line_i === 1'b0) begin
      w++;
      @(posedge sys_clk_i);
    end
    repeat (w / 2) @(posedge sys_clk_i);
    // sample mid-cell, lsb first
    for (int i = 0; i < 8; i++) begin
      b[i] = tx_line_i;
      repeat (w) @(posedge sys_clk_i);
    end
    seen_q.push_back(b);
    width_q.push_back(w);
  end
endmodule
`default_nettype wire

// ---- nsc_map.svh ----
/*
 * constants of the sentence/command port: timing, characters, codes.
 * assumes a single 20 MHz system clock; included by bare name.
 */
`ifndef NSC_MAP_SVH
`define NSC_MAP_SVH
// ======================================================
// clock and serial timing
`define NSC_CLK_HZ 20000000
// bench clock rate seen by the dividers, keeps frames short in simulation
`define NSC_TB_CLK_HZ 921600
`define NSC_BAUD_DEFAULT 9600
`define NSC_BAUD_LIST_0 4800
`define NSC_BAUD_LIST_2 19200
`define NSC_BAUD_LIST_3 38400
`define NSC_BAUD_LIST_4 57600
`define NSC_BAUD_LIST_5 115200
// ======================================================
// framing characters
`define NSC_CH_DOLLAR 8'h24
`define NSC_CH_STAR 8'h2A
`define NSC_CH_COMMA 8'h2C
`define NSC_CH_CR 8'h0D
`define NSC_CH_LF 8'h0A
// ======================================================
// command numbers and defaults
`define NSC_CMD_BAUD 10'h0FB
`define NSC_CMD_MASK 10'h13A
`define NSC_ACT_LO 10'h064
`define NSC_ACT_HI 10'h0C7
`define NSC_MASK_DEFAULT 6'h3F
`define NSC_NTYPES 6
`endif

// ---- nsc_pkg.sv ----
/*
 * types shared by the sentence/command port modules.
 * assumes nsc_map.svh holds all numbers.
 */
package nsc_pkg;
  // ======================================================
  // command parser states
  typedef enum logic [2:0] {
    PS_IDLE, PS_PFX, PS_NUM, PS_BODY, PS_CK1, PS_CK2, PS_CR, PS_LF
  } nsc_pstate_t;
  // ======================================================
  // sentence types, index into the enable mask
  typedef enum logic [2:0] {
    ST_RMC, ST_GGA, ST_GLL, ST_GSA, ST_VTG, ST_GSV
  } nsc_stype_t;
endpackage

// ---- nsc_port.sv ----
/*
 * sentence output and command input port of the positioning receiver.
 * assumes a navigation engine that streams sentence bytes on request,
 * a 20 MHz clock, and supply-sense pins from the power monitor.
 */
`timescale 1ns/1ps
`default_nettype none
`include "nsc_map.svh"
// Operation
// - sentences start after power, no command needed
// - serial output always restarts at 9600 baud
// - commands change baud and sentence set live
// - sentence mask kept while any supply present
// - action commands fire exactly once
// - dollar, prefix, three digit number parsed
// - asterisk, checksum, CR LF end command
// - checksum is XOR between delimiters, hex
// - six sentence types offered
// - send on tx line, receive on rx
module nsc_port #(
  parameter logic [31:0] CMD_PREFIX = 32'h5058_595A, // arbitrary value
  parameter int FIFO_DEPTH = 16,
  parameter int CLK_HZ = `NSC_CLK_HZ // rate the baud divisors assume
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // supply sense pins
  input wire logic main_supply_i,
  input wire logic backup_supply_i,
  // serial pins
  input wire logic rx_i,
  output logic tx_o,
  // navigation engine sentence stream
  output logic nav_req_o,
  output logic [2:0] nav_type_o,
  input wire logic [7:0] nav_data_i,
  input wire logic nav_valid_i,
  input wire logic nav_last_i,
  output logic nav_ready_o,
  // action commands toward the engine
  output logic action_o,
  output logic [9:0] action_num_o,
  output logic [15:0] action_arg_o
);
  // ======================================================
  // divisor per baud value, derived from clock rate
  function automatic logic [15:0] baud_div(input logic [16:0] b);
    int d;
    d = CLK_HZ / ((b == 17'h0) ? 1 : int'(b));
    return 16'(d);
  endfunction
  function automatic logic valid_baud(input logic [16:0] b);
    return b == 17'(`NSC_BAUD_LIST_0) || b == 17'(`NSC_BAUD_DEFAULT) ||
      b == 17'(`NSC_BAUD_LIST_2) || b == 17'(`NSC_BAUD_LIST_3) ||
      b == 17'(`NSC_BAUD_LIST_4) || b == 17'(`NSC_BAUD_LIST_5);
  endfunction
  // ascii hex digit to nibble, upper or lower case
  function automatic logic [4:0] hex_nib(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
    if ((c | 8'h20) >= 8'h61 && (c | 8'h20) <= 8'h66)
      return {1'b1, 4'(c[3:0] + 4'h9)};
    return 5'h00;
  endfunction
  localparam logic [15:0] DIV_DEF = 16'(CLK_HZ / `NSC_BAUD_DEFAULT);
  // ======================================================
  // pin synchronisers, second flop only is read
  logic [1:0] rx_s, main_s, bak_s;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rx_s <= 2'b11;
      main_s <= 2'b00;
      bak_s <= 2'b00;
    end else begin
      rx_s <= {rx_s[0], rx_i};
      main_s <= {main_s[0], main_supply_i};
      bak_s <= {bak_s[0], backup_supply_i};
    end
  end
  logic main_on; // link may run
  logic supply_lost; // both supplies gone
  logic main_d; // for power-up edge
  assign main_on = main_s[1];
  assign supply_lost = !main_s[1] && !bak_s[1];
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) main_d <= 1'b0;
    else main_d <= main_on;
  end
  // ======================================================
  // settings: baud divisor and sentence enable mask
  logic [15:0] div; // live divisor
  logic [15:0] div_pend; // requested divisor
  logic pend; // change waits for idle tx
  logic [5:0] mask; // enabled sentence types
  logic set_baud, set_mask; // from parser
  logic [16:0] arg; // decoded argument
  logic tx_busy;
  // baud: any power-up restarts at default; change only between bytes
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || (main_on && !main_d) || supply_lost) begin
      div <= DIV_DEF;
      pend <= 1'b0;
      div_pend <= DIV_DEF;
    end else if (set_baud) begin
      div_pend <= baud_div(arg);
      pend <= 1'b1;
    end else if (pend && !tx_busy) begin
      div <= div_pend;
      pend <= 1'b0;
    end
  end
  // mask survives main loss while backup holds; both gone -> default
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || supply_lost) mask <= `NSC_MASK_DEFAULT;
    else if (set_mask) mask <= arg[5:0];
  end
  // ======================================================
  // sentence scheduler: round robin over enabled types
  function automatic logic [2:0] next_type(input logic [2:0] c,
                                          input logic [5:0] m);
    logic [2:0] t;
    logic [2:0] r;
    r = c;
    t = c;
    for (int i = 0; i < `NSC_NTYPES; i++) begin
      t = (t == 3'(`NSC_NTYPES - 1)) ? 3'h0 : t + 3'h1;
      if (m[t] && r == c) r = t;
    end
    if (r == c && !m[c]) r = c;
    return r;
  endfunction
  logic busy; // sentence in flight
  logic first; // nothing sent since power-up
  logic [2:0] nxt;
  assign nxt = (first && mask[0]) ? 3'h0 : next_type(nav_type_o, mask);
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !main_on) begin
      busy <= 1'b0;
      first <= 1'b1;
      nav_req_o <= 1'b0;
      nav_type_o <= 3'h0;
    end else begin
      nav_req_o <= 1'b0;
      if (!busy && mask != 6'h00) begin
        nav_req_o <= 1'b1;
        nav_type_o <= nxt;
        busy <= 1'b1;
        first <= 1'b0;
      end else if (nav_valid_i && nav_ready_o && nav_last_i) begin
        busy <= 1'b0;
      end
    end
  end
  // ======================================================
  // fifo between engine and transmitter
  nsc_stream_if #(.W(8)) fin ();
  nsc_stream_if #(.W(8)) fout ();
  assign fin.data = nav_data_i;
  assign fin.valid = nav_valid_i && main_on;
  assign nav_ready_o = fin.ready;
  nsc_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .in_s(fin),
    .out_s(fout)
  );
  // ======================================================
  // transmitter, 8N1, LSB first
  logic [15:0] tx_cnt;
  logic [9:0] tx_sh;
  logic [3:0] tx_bits;
  assign tx_busy = (tx_bits != 4'h0);
  assign fout.ready = !tx_busy && main_on && !pend;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !main_on) begin
      tx_o <= 1'b1; // idle high
      tx_cnt <= '0;
      tx_sh <= '1;
      tx_bits <= 4'h0;
    end else if (fout.valid && fout.ready) begin
      tx_sh <= {1'b1, fout.data, 1'b0};
      // one extra cell so the stop bit lasts a full bit time
      tx_bits <= 4'hB;
      tx_cnt <= '0;
      tx_o <= 1'b1;
    end else if (tx_busy) begin
      if (tx_cnt == 16'h0000) begin
        tx_o <= tx_sh[0];
        tx_sh <= {1'b1, tx_sh[9:1]};
        tx_bits <= tx_bits - 4'h1;
        tx_cnt <= div - 16'h0001;
      end else begin
        tx_cnt <= tx_cnt - 16'h0001;
      end
    end
  end
  // ======================================================
  // receiver: sample mid-bit after start edge
  logic [15:0] rx_cnt;
  logic [3:0] rx_bits;
  logic [7:0] rx_sh;
  logic rx_v; // one-cycle byte strobe
  logic [7:0] rx_b;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !main_on) begin
      rx_bits <= 4'h0;
      rx_cnt <= '0;
      rx_sh <= '0;
      rx_v <= 1'b0;
      rx_b <= '0;
    end else begin
      rx_v <= 1'b0;
      if (rx_bits == 4'h0) begin
        if (!rx_s[1]) begin
          rx_bits <= 4'hA;
          rx_cnt <= {1'b0, div[15:1]};
        end
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end else begin
        rx_cnt <= div - 16'h0001;
        rx_bits <= rx_bits - 4'h1;
        if (rx_bits == 4'hA && rx_s[1]) rx_bits <= 4'h0; // glitch
        else if (rx_bits == 4'h1) begin
          rx_v <= rx_s[1]; // framing error drops byte
          rx_b <= rx_sh;
        end else if (rx_bits != 4'hA) rx_sh <= {rx_s[1], rx_sh[7:1]};
      end
    end
  end
  // ======================================================
  // command parser
  nsc_pkg::nsc_pstate_t ps;
  logic [1:0] pidx; // prefix/digit index
  logic [9:0] num; // command number
  logic [7:0] ck; // running xor
  logic [3:0] ck_hi;
  logic ck_ok; // checksum matched
  logic arg_on; // after first comma
  logic [7:0] pfx_ch;
  logic [4:0] nib;
  assign pfx_ch = CMD_PREFIX[8'(31 - 8 * pidx) -: 8];
  assign nib = hex_nib(rx_b);
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !main_on) begin
      ps <= nsc_pkg::PS_IDLE;
      pidx <= 2'h0;
      num <= '0;
      ck <= '0;
      ck_hi <= '0;
      ck_ok <= 1'b0;
      arg <= '0;
      arg_on <= 1'b0;
    end else if (rx_v) begin
      if (rx_b == `NSC_CH_DOLLAR) begin
        ps <= nsc_pkg::PS_PFX;
        pidx <= 2'h0;
        ck <= 8'h00;
        num <= '0;
        arg <= '0;
        arg_on <= 1'b0;
      end else begin
        unique case (ps)
          nsc_pkg::PS_IDLE: ;
          nsc_pkg::PS_PFX: begin
            ck <= ck ^ rx_b;
            if (rx_b != pfx_ch) ps <= nsc_pkg::PS_IDLE;
            else begin
              pidx <= pidx + 2'h1;
              if (pidx == 2'h3) ps <= nsc_pkg::PS_NUM;
            end
          end
          nsc_pkg::PS_NUM: begin
            ck <= ck ^ rx_b;
            if (rx_b < 8'h30 || rx_b > 8'h39) ps <= nsc_pkg::PS_IDLE;
            else begin
              num <= 10'(num * 10 + 10'(rx_b[3:0]));
              pidx <= pidx + 2'h1;
              if (pidx == 2'h2) ps <= nsc_pkg::PS_BODY;
            end
          end
          nsc_pkg::PS_BODY: begin
            if (rx_b == `NSC_CH_STAR) ps <= nsc_pkg::PS_CK1;
            else begin
              ck <= ck ^ rx_b;
              if (rx_b == `NSC_CH_COMMA) arg_on <= !arg_on && arg == '0;
              else if (arg_on && rx_b >= 8'h30 && rx_b <= 8'h39)
                arg <= 17'(arg * 10 + 17'(rx_b[3:0]));
            end
          end
          nsc_pkg::PS_CK1: begin
            ck_hi <= nib[3:0];
            ps <= nib[4] ? nsc_pkg::PS_CK2 : nsc_pkg::PS_IDLE;
          end
          nsc_pkg::PS_CK2: begin
            ck_ok <= nib[4] && {ck_hi, nib[3:0]} == ck;
            ps <= nib[4] ? nsc_pkg::PS_CR : nsc_pkg::PS_IDLE;
          end
          nsc_pkg::PS_CR:
            ps <= (rx_b == `NSC_CH_CR) ? nsc_pkg::PS_LF
                                       : nsc_pkg::PS_IDLE;
          nsc_pkg::PS_LF: ps <= nsc_pkg::PS_IDLE;
        endcase
      end
    end
  end
  // ======================================================
  // execute on LF of a well formed, checked command
  logic done;
  assign done = rx_v && ps == nsc_pkg::PS_LF && rx_b == `NSC_CH_LF;
  assign set_baud = done && ck_ok && num == `NSC_CMD_BAUD && valid_baud(arg);
  assign set_mask = done && ck_ok && num == `NSC_CMD_MASK;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      action_o <= 1'b0;
      action_num_o <= '0;
      action_arg_o <= '0;
    end else begin
      action_o <= done && ck_ok && num >= `NSC_ACT_LO &&
                  num <= `NSC_ACT_HI;
      if (done) begin
        action_num_o <= num;
        action_arg_o <= arg[15:0];
      end
    end
  end
  // ======================================================
  // checks
  a_baud_powerup: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    main_on && !main_d |=> div == DIV_DEF)
    else $error("baud not default after power-up");
  a_first_req: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    main_on && !main_d && mask != 6'h00 |-> ##[1:3] nav_req_o)
    else $error("no sentence after power-up");
  a_mask_keep: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !supply_lost && !set_mask |=> mask == $past(mask))
    else $error("mask changed without command");
  a_mask_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    supply_lost |=> mask == `NSC_MASK_DEFAULT)
    else $error("mask not default after supply loss");
  a_action_once: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    action_o |=> !action_o)
    else $error("action repeated");
  a_action_ck: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    action_o |-> $past(ck_ok) && $past(done))
    else $error("action without good checksum");
  a_req_enabled: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    nav_req_o |-> mask[nav_type_o] && nav_type_o < 3'h6)
    else $error("request for disabled sentence");
  a_prefix_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    main_on && rx_v && rx_b == `NSC_CH_DOLLAR |=> ps == nsc_pkg::PS_PFX)
    else $error("dollar did not restart parser");
  a_tx_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !main_on |=> tx_o && !tx_busy)
    else $error("tx active without main supply");
  c_baud_cmd: cover property (@(posedge sys_clk_i) set_baud);
  c_action: cover property (@(posedge sys_clk_i) action_o);
  c_bad_ck: cover property (@(posedge sys_clk_i) done && !ck_ok);
  c_fifo_full: cover property (@(posedge sys_clk_i) !nav_ready_o);
endmodule
`default_nettype wire

// ---- nsc_stream_if.sv ----
/*
 * byte stream carrier between the port and its fifo.
 * assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface nsc_stream_if #(parameter int W = 8);
  logic [W-1:0] data; // payload
  logic valid; // source holds data
  logic ready; // sink takes data
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire
